// *** fcg_pkg.sv ***
package fcg_pkg;

   // Register offsets
   localparam logic [2:0] OFF_CTRL1  = 3'h0;
   localparam logic [2:0] OFF_CTRL2  = 3'h1;
   localparam logic [2:0] OFF_STAT1  = 3'h2;
   localparam logic [2:0] OFF_STAT2  = 3'h3;
   localparam logic [2:0] OFF_TRIM   = 3'h4;
   localparam logic [2:0] OFF_FREQ   = 3'h5;

   // Control one fields
   localparam int C1_HGO    = 7;
   localparam int C1_RANGE  = 6;
   localparam int C1_REFERENCE_SELECT   = 5;
   localparam int C1_CLOCK_MODE_SELECT_H = 4;
   localparam int C1_CLOCK_MODE_SELECT_L = 3;
   localparam int C1_OSTEN  = 2;
   localparam int C1_CLOCK_LOSS_DETECT_DISABLE   = 1;
   localparam logic [7:0] C1_WMASK = 8'hFE;

   // Control two fields
   localparam int C2_LOCK_LOSS_RESET_ENABLE  = 7;
   localparam int C2_MFD_H  = 6;
   localparam int C2_MFD_L  = 4;
   localparam int C2_CLOCK_LOSS_RESET_ENABLE  = 3;
   localparam int C2_RFD_H  = 2;
   localparam int C2_RFD_L  = 0;

   // Status fields
   localparam int S1_CLKST_H = 7;
   localparam int S1_CLKST_L = 6;
   localparam int S1_LOLS    = 4;
   localparam int S1_LOCK    = 3;
   localparam int S1_LOCS    = 2;
   localparam int S1_ERCS    = 1;
   localparam int S1_IRQF    = 0;
   localparam int S2_OSCILLATOR_STABLE_FLAG    = 0;

   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] TRIM_RST  = 8'h80;

   // Mode codes
   localparam logic [1:0] CLOCK_MODE_SELECT_SCM = 2'h0;
   localparam logic [1:0] CLOCK_MODE_SELECT_FEI = 2'h1;
   localparam logic [1:0] CLOCK_MODE_SELECT_FBE = 2'h2;
   localparam logic [1:0] CLOCK_MODE_SELECT_FEE = 2'h3;

   // Frequencies in kHz, with the reference divider and prescale factors
   localparam int SCM_OUT_KHZ  = 8000;
   localparam int SCM_BUS_KHZ  = 4000;
   localparam int IRG_KHZ      = 243;
   localparam int IRG_DIV      = 7;
   localparam int PRESCALE_LO  = 64;
   localparam int PRESCALE_HI  = 1;

   // Timing
   localparam int CLK_MHZ       = 100;
   localparam int STABLE_US     = 10;
   localparam int STABLE_CYCLES = STABLE_US * CLK_MHZ;

   typedef enum logic [3:0]
   {
      FCG_SCM = 4'h1,
      FCG_FEI = 4'h2,
      FCG_FBE = 4'h4,
      FCG_FEE = 4'h8
   } fcg_mode_t;

endpackage : fcg_pkg

// *** fcg_cfg_if.sv ***
`timescale 1ns/1ns
interface fcg_cfg_if;
   logic [2:0] mult_code;
   logic [2:0] div_code;
   logic       range_hi;
   logic [1:0] clock_mode_select;
   logic [31:0] freq_khz;

   modport ctrl
   (
      output mult_code,
      output div_code,
      output range_hi,
      output clock_mode_select,
      input  freq_khz
   );
   modport calc
   (
      input  mult_code,
      input  div_code,
      input  range_hi,
      input  clock_mode_select,
      output freq_khz
   );
endinterface : fcg_cfg_if

// *** fcg_freq_calc.sv ***
`timescale 1ns/1ns
module fcg_freq_calc
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [31:0] ext_khz,
   fcg_cfg_if.calc          cfg
);

   function automatic logic [4:0] fcg_mult(input logic [2:0] code);
      fcg_mult = {1'b0, code, 1'b0} + 5'h04;
   endfunction : fcg_mult

   logic [31:0] prescale;
   logic [31:0] base;
   logic [31:0] prod;
   logic [31:0] freq_reg;
   logic [31:0] freq_next;

   always_comb
   begin
      prescale = cfg.range_hi ? 32'(fcg_pkg::PRESCALE_HI) : 32'(fcg_pkg::PRESCALE_LO);
      base     = ext_khz * prescale;
      if (cfg.clock_mode_select == fcg_pkg::CLOCK_MODE_SELECT_FEI)
      begin
         base = 32'((fcg_pkg::IRG_KHZ * fcg_pkg::PRESCALE_LO) / fcg_pkg::IRG_DIV);
      end
      prod = base * 32'(fcg_mult(cfg.mult_code));
      freq_next = prod >> cfg.div_code;
      if (cfg.clock_mode_select == fcg_pkg::CLOCK_MODE_SELECT_SCM)
      begin
         freq_next = 32'(fcg_pkg::SCM_OUT_KHZ);
      end
      else if (cfg.clock_mode_select == fcg_pkg::CLOCK_MODE_SELECT_FBE)
      begin
         freq_next = ext_khz >> cfg.div_code;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         freq_reg <= 32'(fcg_pkg::SCM_OUT_KHZ);
      end
      else
      begin
         freq_reg <= freq_next;
      end
   end

   assign cfg.freq_khz = freq_reg;

endmodule : fcg_freq_calc

// *** fcg_clock_generator.sv ***
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module fcg_clock_generator
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [7:0]  rdata,
   input  wire logic [31:0] ext_khz,
   input  wire logic        ext_clock_present,
   input  wire logic        loop_locked,
   output logic             osc_high_range,
   output logic             osc_high_gain,
   output logic             osc_enable,
   output logic             irg_enable,
   output logic             dco_enable,
   output logic             loop_engaged,
   output logic      [7:0]  irg_trim,
   output logic      [31:0] out_freq_khz,
   output logic      [31:0] bus_freq_khz,
   output fcg_pkg::fcg_mode_t mode,
   output logic             irq,
   output logic             lock_loss_reset,
   output logic             clock_loss_reset
);

   logic [7:0]  ctrl1_reg;
   logic [7:0]  ctrl2_reg;
   logic [7:0]  trim_reg;
   logic        lols_reg;
   logic        locs_reg;
   logic        irqf_reg;
   logic        locked_d_reg;
   logic        oscillator_stable_flag_reg;
   logic [15:0] stable_cnt_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic [1:0]  clock_mode_select;
   logic        lock_lost;
   logic        clk_lost;
   logic        wr_s1;
   logic        ext_mode;

   fcg_cfg_if cfg ();

   //////////////////////////////////////////////////////////////////////////
   // Control registers
   assign clock_mode_select = ctrl1_reg[fcg_pkg::C1_CLOCK_MODE_SELECT_H:fcg_pkg::C1_CLOCK_MODE_SELECT_L];

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         ctrl1_reg <= fcg_pkg::CTRL1_RST;
      end
      else if (wr_stb && addr == fcg_pkg::OFF_CTRL1)
      begin
         ctrl1_reg <= wdata & fcg_pkg::C1_WMASK;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         ctrl2_reg <= fcg_pkg::CTRL2_RST;
      end
      else if (wr_stb && addr == fcg_pkg::OFF_CTRL2)
      begin
         ctrl2_reg <= wdata;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         trim_reg <= fcg_pkg::TRIM_RST;
      end
      else if (wr_stb && addr == fcg_pkg::OFF_TRIM)
      begin
         trim_reg <= wdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Mode decode
   always_comb
   begin
      case (clock_mode_select)
         fcg_pkg::CLOCK_MODE_SELECT_FEI: mode = fcg_pkg::FCG_FEI;
         fcg_pkg::CLOCK_MODE_SELECT_FBE: mode = fcg_pkg::FCG_FBE;
         fcg_pkg::CLOCK_MODE_SELECT_FEE: mode = fcg_pkg::FCG_FEE;
         default:           mode = fcg_pkg::FCG_SCM;
      endcase
   end

   assign ext_mode       = (mode == fcg_pkg::FCG_FEE) || (mode == fcg_pkg::FCG_FBE);
   assign osc_high_range = ctrl1_reg[fcg_pkg::C1_RANGE];
   assign osc_high_gain  = ctrl1_reg[fcg_pkg::C1_HGO];
   assign osc_enable     = ctrl1_reg[fcg_pkg::C1_REFERENCE_SELECT]
                           && (ext_mode || ctrl1_reg[fcg_pkg::C1_OSTEN]);
   assign irg_enable     = (mode == fcg_pkg::FCG_FEI);
   assign dco_enable     = (mode != fcg_pkg::FCG_FBE);
   assign loop_engaged   = (mode == fcg_pkg::FCG_FEI) || (mode == fcg_pkg::FCG_FEE);
   assign irg_trim       = trim_reg;

   //////////////////////////////////////////////////////////////////////////
   // Frequency
   assign cfg.mult_code = ctrl2_reg[fcg_pkg::C2_MFD_H:fcg_pkg::C2_MFD_L];
   assign cfg.div_code  = ctrl2_reg[fcg_pkg::C2_RFD_H:fcg_pkg::C2_RFD_L];
   assign cfg.range_hi  = ctrl1_reg[fcg_pkg::C1_RANGE];
   assign cfg.clock_mode_select      = clock_mode_select;

   fcg_freq_calc u_calc
   (
      .clock   (clock),
      .reset_n (reset_n),
      .ext_khz (ext_khz),
      .cfg     (cfg)
   );

   assign out_freq_khz = cfg.freq_khz;
   assign bus_freq_khz = {1'b0, cfg.freq_khz[31:1]};

   //////////////////////////////////////////////////////////////////////////
   // Loss events and status
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         locked_d_reg <= 1'b0;
      end
      else
      begin
         locked_d_reg <= loop_locked && loop_engaged;
      end
   end

   assign lock_lost = locked_d_reg && !loop_locked && loop_engaged;
   assign clk_lost  = ext_mode && !ctrl1_reg[fcg_pkg::C1_CLOCK_LOSS_DETECT_DISABLE] && !ext_clock_present;
   assign wr_s1     = wr_stb && addr == fcg_pkg::OFF_STAT1 && wdata[fcg_pkg::S1_IRQF];

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         lols_reg <= 1'b0;
         locs_reg <= 1'b0;
      end
      else
      begin
         lols_reg <= lock_lost || (lols_reg && !wr_s1);
         locs_reg <= clk_lost || (locs_reg && !wr_s1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         irqf_reg <= 1'b0;
      end
      else if ((lock_lost && !ctrl2_reg[fcg_pkg::C2_LOCK_LOSS_RESET_ENABLE])
               || (clk_lost && !ctrl2_reg[fcg_pkg::C2_CLOCK_LOSS_RESET_ENABLE]))
      begin
         irqf_reg <= 1'b1;
      end
      else if (wr_s1)
      begin
         irqf_reg <= 1'b0;
      end
   end

   assign irq              = irqf_reg;
   assign lock_loss_reset  = lock_lost && ctrl2_reg[fcg_pkg::C2_LOCK_LOSS_RESET_ENABLE];
   assign clock_loss_reset = clk_lost && ctrl2_reg[fcg_pkg::C2_CLOCK_LOSS_RESET_ENABLE];

   // Oscillator settle after any control one or control two write
   always_ff @(posedge clock)
   begin
      if (!reset_n || (wr_stb && (addr == fcg_pkg::OFF_CTRL1 || addr == fcg_pkg::OFF_CTRL2)))
      begin
         stable_cnt_reg <= 16'h0000;
         oscillator_stable_flag_reg       <= 1'b0;
      end
      else if (stable_cnt_reg == 16'(fcg_pkg::STABLE_CYCLES - 1))
      begin
         oscillator_stable_flag_reg <= 1'b1;
      end
      else
      begin
         stable_cnt_reg <= stable_cnt_reg + 16'h0001;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read path
   always_comb
   begin
      rdata_next = 8'h00;
      if (addr == fcg_pkg::OFF_CTRL1)
      begin
         rdata_next = ctrl1_reg & fcg_pkg::C1_WMASK;
      end
      else if (addr == fcg_pkg::OFF_CTRL2)
      begin
         rdata_next = ctrl2_reg;
      end
      else if (addr == fcg_pkg::OFF_STAT1)
      begin
         rdata_next[fcg_pkg::S1_CLKST_H:fcg_pkg::S1_CLKST_L] = clock_mode_select;
         rdata_next[fcg_pkg::S1_LOLS] = lols_reg;
         rdata_next[fcg_pkg::S1_LOCK] = loop_locked && loop_engaged;
         rdata_next[fcg_pkg::S1_LOCS] = locs_reg;
         rdata_next[fcg_pkg::S1_ERCS] = ext_clock_present;
         rdata_next[fcg_pkg::S1_IRQF] = irqf_reg;
      end
      else if (addr == fcg_pkg::OFF_STAT2)
      begin
         rdata_next[fcg_pkg::S2_OSCILLATOR_STABLE_FLAG] = oscillator_stable_flag_reg;
      end
      else if (addr == fcg_pkg::OFF_TRIM)
      begin
         rdata_next = trim_reg;
      end
      else if (addr == fcg_pkg::OFF_FREQ)
      begin
         rdata_next = cfg.freq_khz[7:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         rdata_reg <= 8'h00;
      end
      else if (rd_stb)
      begin
         rdata_reg <= rdata_next;
      end
      else
      begin
         rdata_reg <= 8'h00;
      end
   end

   assign rdata = rdata_reg;

endmodule : fcg_clock_generator

// *** fcg_clock_generator_chk.sv ***
`timescale 1ns/1ns
module fcg_clock_generator_chk
(
   input wire logic               clock,
   input wire logic               reset_n,
   input wire logic [2:0]         addr,
   input wire logic [7:0]         wdata,
   input wire logic               wr_stb,
   input wire logic               rd_stb,
   input wire logic [7:0]         rdata,
   input wire logic               loop_locked,
   input wire logic               osc_high_range,
   input wire logic               osc_high_gain,
   input wire logic               loop_engaged,
   input wire logic               irg_enable,
   input wire logic [7:0]         irg_trim,
   input wire logic [31:0]        out_freq_khz,
   input wire logic [31:0]        bus_freq_khz,
   input wire fcg_pkg::fcg_mode_t mode,
   input wire logic               irq,
   input wire logic               lock_loss_reset
);
   logic [7:0] wd_q;
   always_ff @(posedge clock) wd_q <= wdata;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   property p_c1_bit0; rd_stb && addr == fcg_pkg::OFF_CTRL1 |=> rdata[0] == 1'b0; endproperty
   a_c1_bit0: assert property (p_c1_bit0) else $error("control one bit 0 set");
   property p_bus_half; bus_freq_khz == (out_freq_khz >> 1); endproperty
   a_bus_half: assert property (p_bus_half) else $error("bus not half output");
   property p_scm; (mode == fcg_pkg::FCG_SCM) [*3] |-> out_freq_khz == 32'h1F40; endproperty
   a_scm: assert property (p_scm) else $error("self clocked freq wrong");
   property p_eng; loop_engaged == (mode == fcg_pkg::FCG_FEI || mode == fcg_pkg::FCG_FEE); endproperty
   a_eng: assert property (p_eng) else $error("engaged mismatch");
   property p_irg; irg_enable == (mode == fcg_pkg::FCG_FEI); endproperty
   a_irg: assert property (p_irg) else $error("internal ref enable wrong");
   property p_osc; wr_stb && addr == fcg_pkg::OFF_CTRL1 |=> {osc_high_gain, osc_high_range} == wd_q[7:6]; endproperty
   a_osc: assert property (p_osc) else $error("gain or range wrong");
   property p_trim; wr_stb && addr == fcg_pkg::OFF_TRIM |=> irg_trim == wd_q; endproperty
   a_trim: assert property (p_trim) else $error("trim not stored");
   property p_lol; $fell(loop_locked) && loop_engaged |-> ##[0:2] (irq || lock_loss_reset); endproperty
   a_lol: assert property (p_lol) else $error("lock loss unreported");
   property p_hold; $past(irq) && !$past(wr_stb) |-> irq; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   c_fee: cover property (mode == fcg_pkg::FCG_FEE);
   c_fei: cover property (mode == fcg_pkg::FCG_FEI);
   c_irq: cover property ($rose(irq));
endmodule : fcg_clock_generator_chk
bind fcg_clock_generator fcg_clock_generator_chk fcg_clock_generator_chk_inst
(
   .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .loop_locked(loop_locked), .osc_high_range(osc_high_range),
   .osc_high_gain(osc_high_gain), .loop_engaged(loop_engaged), .irg_enable(irg_enable),
   .irg_trim(irg_trim), .out_freq_khz(out_freq_khz), .bus_freq_khz(bus_freq_khz),
   .mode(mode), .irq(irq), .lock_loss_reset(lock_loss_reset)
);

// *** fcg_ext_ref.sv ***
`timescale 1ns/1ns
module fcg_ext_ref
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        osc_enable,
   input  wire logic        loop_engaged,
   input  wire logic        kill_clk,
   input  wire logic        kill_lock,
   output logic      [31:0] ext_khz,
   output logic             ext_clock_present,
   output logic             loop_locked
);
   logic [2:0] cnt;
   assign ext_khz = 32'h0FA0;
   assign ext_clock_present = osc_enable && !kill_clk;
   // Lock after a few cycles engaged
   always_ff @(posedge clock)
   begin
      if (!reset_n || !loop_engaged || kill_lock)
         cnt <= 3'h0;
      else if (cnt != 3'h4)
         cnt <= cnt + 3'h1;
   end
   assign loop_locked = (cnt == 3'h4);
endmodule : fcg_ext_ref

// *** test_fll_clock_generator_config.sv ***
`timescale 1ns/1ns
module test_fll_clock_generator_config;
   logic clock, reset_n, wr_stb, rd_stb, kill_clk, kill_lock, ecp, lck, seen;
   logic hr, hg, oe, lle, irq, llr, ie, de, clr;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, d, c1, c2, trim;
   logic [31:0] ext, ofq, bfq;
   fcg_pkg::fcg_mode_t mode;
   int n_mismatch, compares, i;
   fcg_clock_generator fcg_clock_generator_inst
   (
      .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .ext_khz(ext), .ext_clock_present(ecp),
      .loop_locked(lck), .osc_high_range(hr), .osc_high_gain(hg), .osc_enable(oe),
      .irg_enable(ie), .dco_enable(de), .loop_engaged(lle), .irg_trim(trim),
      .out_freq_khz(ofq), .bus_freq_khz(bfq), .mode(mode), .irq(irq),
      .lock_loss_reset(llr), .clock_loss_reset(clr)
   );
   fcg_ext_ref fcg_ext_ref_inst
   (
      .clock(clock), .reset_n(reset_n), .osc_enable(oe), .loop_engaged(lle),
      .kill_clk(kill_clk), .kill_lock(kill_lock), .ext_khz(ext),
      .ext_clock_present(ecp), .loop_locked(lck)
   );
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_freq(input logic [7:0] a, input logic [7:0] b);
      logic [31:0] n;
      n = 32'h4 + 32'h2 * b[6:4];
      case (a[4:3])
         2'h3: return (32'h0FA0 * (a[6] ? fcg_pkg::PRESCALE_HI : fcg_pkg::PRESCALE_LO) * n) >> b[2:0];
         2'h1: return (fcg_pkg::IRG_KHZ * fcg_pkg::PRESCALE_LO / fcg_pkg::IRG_DIV * n) >> b[2:0];
         2'h2: return 32'h0FA0 >> b[2:0];
         default: return 32'h1F40;
      endcase
   endfunction : exp_freq
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      #1;
   endtask : wr
   task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask : rchk
   task automatic cfg(input logic [7:0] a, input logic [7:0] b);
      wr(fcg_pkg::OFF_CTRL1, a);
      wr(fcg_pkg::OFF_CTRL2, b);
      repeat (2) @(posedge clock);
      #1;
      chk(ofq, exp_freq(a, b));
      chk(bfq, exp_freq(a, b) >> 1);
      chk(mode, 32'h1 << a[4:3]);
      chk({hg, hr}, a[7:6]);
      chk(oe, a[5] & (a[4] | a[2]));
      chk({ie, de}, {a[4:3] == 2'h1, a[4:3] != 2'h2});
   endtask : cfg
   task automatic lose(input logic [7:0] b);
      cfg(8'h78, b);
      for (i = 0; i < 64 && lck !== 1'b1; i++) @(posedge clock);
      if (lck !== 1'b1)
      begin
         n_mismatch++;
         report_and_stop();
      end
      wr(fcg_pkg::OFF_STAT1, 8'h01);
      seen = 1'b0;
      kill_lock <= 1'b1;
      repeat (4) @(posedge clock) seen |= (llr === 1'b1);
      #1;
      chk({seen, irq}, b[7] ? 2'h2 : 2'h1);
   endtask : lose
   task automatic report_and_stop();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      repeat (50000) @(posedge clock);
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      {reset_n, wr_stb, rd_stb, kill_clk, kill_lock, addr, wdata} = '0;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(32'hA77CE8CD));
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      chk(ofq, 32'h1F40);
      chk(bfq, 32'h0FA0);
      chk(mode, 32'h1);
      rchk(fcg_pkg::OFF_CTRL1, 8'hFF, 8'h00);
      rchk(fcg_pkg::OFF_TRIM, 8'hFF, fcg_pkg::TRIM_RST);
      wr(fcg_pkg::OFF_CTRL1, 8'hFF);
      rchk(fcg_pkg::OFF_CTRL1, 8'hFF, 8'hFE);
      wr(3'h6, 8'hFF);
      rchk(3'h6, 8'hFF, 8'h00);
      c1 = 8'($urandom);
      wr(fcg_pkg::OFF_TRIM, c1);
      rchk(fcg_pkg::OFF_TRIM, 8'hFF, c1);
      rchk(fcg_pkg::OFF_STAT2, 8'h01, 8'h00);
      repeat (fcg_pkg::STABLE_CYCLES) @(posedge clock);
      wr(fcg_pkg::OFF_STAT2, 8'h00);
      rchk(fcg_pkg::OFF_STAT2, 8'h01, 8'h01);
      cfg(8'h38, 8'h00);
      cfg(8'h78, 8'h30);
      cfg(8'h28, 8'h31);
      cfg(8'h28, 8'h32);
      wr(fcg_pkg::OFF_TRIM, 8'h7C);
      cfg(8'h28, 8'h31);
      for (int k = 0; k < 64; k++)
      begin
         c1 = {3'($urandom), 2'($urandom), 3'h0};
         c2 = {1'b0, 3'(k >> 3), 1'b0, 3'(k)};
         cfg(c1, c2);
      end
      lose(8'h30);
      rchk(fcg_pkg::OFF_STAT1, 8'h11, 8'h11);
      wr(fcg_pkg::OFF_STAT1, 8'h01);
      chk(irq, 1'b0);
      kill_lock <= 1'b0;
      lose(8'hB0);
      kill_lock <= 1'b0;
      cfg(8'h78, 8'h30);
      wr(fcg_pkg::OFF_STAT1, 8'h01);
      kill_clk <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(irq, 1'b1);
      chk(clr, 1'b0);
      rchk(fcg_pkg::OFF_STAT1, 8'h04, 8'h04);
      report_and_stop();
   end
endmodule : test_fll_clock_generator_config
